// file: hdl/adcsq_defs.vh
// Constants for the converter channel sequencer
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH
// Register word addresses
`define ADCSQ_ADDR_CTRL 2'h0
`define ADCSQ_ADDR_STAT 2'h1
`define ADCSQ_ADDR_DATA 2'h2
// Control register fields
`define ADCSQ_CTRL_W 13
`define ADCSQ_CTRL_RST 13'h0000
`define ADCSQ_B_RANGE 0
`define ADCSQ_B_SEQLO 1
`define ADCSQ_B_SEQHI 2
`define ADCSQ_F_MODE 4:3
`define ADCSQ_F_ADDR 6:5
`define ADCSQ_B_REF 8
`define ADCSQ_B_CODING 9
`define ADCSQ_F_PWR 11:10
`define ADCSQ_B_TENBIT 12
// Sequence select encodings
`define ADCSQ_SEQ_MANUAL 2'h0
`define ADCSQ_SEQ_CONSEC 2'h3
// Input configuration encodings
`define ADCSQ_MODE_SINGLE 2'h0
`define ADCSQ_MODE_PSEUDO 2'h1
`define ADCSQ_MODE_DIFF 2'h2
// Power control encodings
`define ADCSQ_PWR_NORMAL 2'h0
`define ADCSQ_PWR_AUTOSHDN 2'h1
`define ADCSQ_PWR_AUTOSTBY 2'h2
`define ADCSQ_PWR_FULLSHDN 2'h3
// Code resolution
`define ADCSQ_RES 12
`define ADCSQ_RES_LOW 10
`define ADCSQ_MSB 4'hB
`define ADCSQ_LSB10 4'h2
`define ADCSQ_DAC_FIRST 12'h800
`define ADCSQ_RDATA_W 16
`endif

// file: hdl/adcsq_sequencer.v
// Channel sequencer, input mux control and SAR control for a 4-input ADC
// Function
// - Manual mode converts last written channel address
// - Consecutive mode runs channel 0 to final
// - Paired sequencing never converts swapped pairs
// - Each convert-start falling edge while idle advances sequencer in consecutive mode
// - Range bit: span reference or twice reference
// - Coding bit: straight binary or twos complement
// - Code steps one LSB, 10 or 12 bit
// - Two-bit power field selects power behaviour
// - Configuration 00 gives four single-ended channels
// - Single-ended negative side tied to ground
// - Inputs disconnected during conversion, code after
// - Address selects positive input, pairs 0/1, 2/3
// - Configuration field decodes single, diff, pseudo
// - Wrap to channel 0 until next write
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "adcsq_defs.vh"

module adcsq_sequencer (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Register port
  input wire [1:0] regAddr,
  input wire [`ADCSQ_CTRL_W-1:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [`ADCSQ_RDATA_W-1:0] regRdData,
  // Conversion control
  input wire convert_start_n,
  output reg busy,
  output reg dataValid,
  output reg [`ADCSQ_RES-1:0] resultCode,
  output reg [1:0] resultChannel,
  // Analog front end control
  output reg [1:0] posSelect,
  output reg [1:0] negSelect,
  output reg negToGround,
  output reg sampleConnect,
  output reg rangeDouble,
  output reg refInternal,
  input wire compAbove,
  output reg [`ADCSQ_RES-1:0] dacCode,
  // Power control
  output reg corePowered,
  output reg refPowered,
  output reg refBufPowered
);

  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [`ADCSQ_CTRL_W-1:0] ctrl_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg convPrev_r;
  reg [1:0] seqAddr_r;
  reg [1:0] seqAddr_nxt;
  reg [1:0] convChan_r;
  reg [3:0] bitIdx_r;
  reg [`ADCSQ_RES-1:0] sar_r;
  reg powerDown_r;

  wire startEdge;
  wire [1:0] seqSel;
  wire [1:0] modeSel;
  wire [1:0] finalAddr;
  wire [1:0] pwrSel;
  wire paired;
  wire [1:0] chanNow;
  wire [3:0] lastBit;

  // Mixed sequence encodings are left to the host to avoid
  assign seqSel = {ctrl_r[`ADCSQ_B_SEQHI], ctrl_r[`ADCSQ_B_SEQLO]};
  assign modeSel = ctrl_r[`ADCSQ_F_MODE];
  assign finalAddr = ctrl_r[`ADCSQ_F_ADDR];
  assign pwrSel = ctrl_r[`ADCSQ_F_PWR];
  // Unused configuration 11 falls back to single-ended
  assign paired = (modeSel == `ADCSQ_MODE_DIFF) ||
    (modeSel == `ADCSQ_MODE_PSEUDO);
  // Falling edge of convert start; input already synchronous
  assign startEdge = convPrev_r & ~convert_start_n;
  assign chanNow = (seqSel == `ADCSQ_SEQ_CONSEC) ?
    seqAddr_r : finalAddr;
  // Ten-bit variant stops two trials early
  assign lastBit = ctrl_r[`ADCSQ_B_TENBIT] ?
    `ADCSQ_LSB10 : 4'h0;

  // Negative input for a given address in paired modes
  function [1:0] pairMate;
    input [1:0] addr;
    begin
      pairMate = {addr[1], ~addr[0]};
    end
  endfunction

  // Next sequence address; paired modes skip swapped pairs
  always @* begin
    seqAddr_nxt = seqAddr_r;
    if (paired) begin
      if (seqAddr_r[1] == finalAddr[1]) begin
        seqAddr_nxt = 2'h0;
      end else begin
        seqAddr_nxt = 2'h2;
      end
    end else begin
      if (seqAddr_r == finalAddr) begin
        seqAddr_nxt = 2'h0;
      end else begin
        seqAddr_nxt = seqAddr_r + 2'h1;
      end
    end
  end

  // Control register; a write restarts the sequence at channel 0
  always @(posedge clock) begin
    if (reset) begin
      ctrl_r <= `ADCSQ_CTRL_RST;
      seqAddr_r <= 2'h0;
    end else if (regWrite && regAddr == `ADCSQ_ADDR_CTRL) begin
      ctrl_r <= regWrData;
      seqAddr_r <= 2'h0;
    end else if (startEdge && state_r == ST_IDLE &&
        seqSel == `ADCSQ_SEQ_CONSEC) begin
      seqAddr_r <= seqAddr_nxt;
    end
  end

  // Edge detector history
  always @(posedge clock) begin
    if (reset) begin
      convPrev_r <= 1'b1;
    end else begin
      convPrev_r <= convert_start_n;
    end
  end

  // Conversion state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (startEdge) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (bitIdx_r == lastBit) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Successive approximation: one trial bit per clock
  always @(posedge clock) begin
    if (reset) begin
      state_r <= ST_IDLE;
      bitIdx_r <= `ADCSQ_MSB;
      sar_r <= {`ADCSQ_RES{1'b0}};
      convChan_r <= 2'h0;
      dacCode <= {`ADCSQ_RES{1'b0}};
    end else begin
      state_r <= state_nxt;
      case (state_r)
        ST_IDLE: begin
          if (startEdge) begin
            bitIdx_r <= `ADCSQ_MSB;
            sar_r <= {`ADCSQ_RES{1'b0}};
            convChan_r <= chanNow;
            dacCode <= `ADCSQ_DAC_FIRST;
          end
        end
        ST_CONV: begin
          // Keep the trial bit if input is above the DAC level
          sar_r[bitIdx_r] <= compAbove;
          dacCode[bitIdx_r] <= compAbove;
          if (bitIdx_r != lastBit) begin
            bitIdx_r <= bitIdx_r - 4'h1;
            // Registered trial word: next bit is tried one clock on
            dacCode[bitIdx_r - 4'h1] <= 1'b1;
          end
        end
        default: begin
          bitIdx_r <= `ADCSQ_MSB;
        end
      endcase
    end
  end

  // Result, coded once the comparison has finished
  always @(posedge clock) begin
    if (reset) begin
      resultCode <= {`ADCSQ_RES{1'b0}};
      resultChannel <= 2'h0;
      dataValid <= 1'b0;
    end else begin
      dataValid <= 1'b0;
      if (state_r == ST_DONE) begin
        resultCode <= sar_r;
        resultChannel <= convChan_r;
        dataValid <= 1'b1;
        // Twos complement flips the top code bit
        if (ctrl_r[`ADCSQ_B_CODING]) begin
          resultCode[`ADCSQ_MSB] <= ~sar_r[`ADCSQ_MSB];
        end
      end
    end
  end

  // Input mux; held at the converted channel while converting
  always @(posedge clock) begin
    if (reset) begin
      posSelect <= 2'h0;
      negSelect <= 2'h0;
      negToGround <= 1'b1;
      sampleConnect <= 1'b1;
      busy <= 1'b0;
    end else begin
      busy <= (state_nxt != ST_IDLE);
      // Both inputs leave the array from the sampling edge
      sampleConnect <= (state_nxt == ST_IDLE);
      if (state_nxt == ST_IDLE) begin
        posSelect <= chanNow;
        negSelect <= paired ? pairMate(chanNow) : 2'h0;
        negToGround <= ~paired;
      end
    end
  end

  // Range and reference selects are plain static decodes
  always @(posedge clock) begin
    if (reset) begin
      rangeDouble <= 1'b0;
      refInternal <= 1'b0;
    end else begin
      rangeDouble <= ctrl_r[`ADCSQ_B_RANGE];
      refInternal <= ctrl_r[`ADCSQ_B_REF];
    end
  end

  // Auto modes sleep after a conversion and wake on the next start
  always @(posedge clock) begin
    if (reset) begin
      powerDown_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      // Set wins: a start edge here is ignored by the converter
      powerDown_r <= 1'b1;
    end else if (startEdge) begin
      powerDown_r <= 1'b0;
    end
  end

  // Power enables; full shutdown keeps the control register
  always @(posedge clock) begin
    if (reset) begin
      corePowered <= 1'b1;
      refPowered <= 1'b1;
      refBufPowered <= 1'b1;
    end else begin
      case (pwrSel)
        `ADCSQ_PWR_NORMAL: begin
          corePowered <= 1'b1;
          refPowered <= 1'b1;
          refBufPowered <= 1'b1;
        end
        `ADCSQ_PWR_AUTOSHDN: begin
          corePowered <= ~powerDown_r;
          refPowered <= ~powerDown_r;
          refBufPowered <= ~powerDown_r;
        end
        `ADCSQ_PWR_AUTOSTBY: begin
          // Reference stays up so wake-up is short
          corePowered <= ~powerDown_r;
          refPowered <= 1'b1;
          refBufPowered <= ~powerDown_r;
        end
        default: begin
          corePowered <= 1'b0;
          refPowered <= 1'b0;
          refBufPowered <= 1'b0;
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge clock) begin
    if (reset) begin
      regRdData <= {`ADCSQ_RDATA_W{1'b0}};
    end else if (regRead) begin
      case (regAddr)
        `ADCSQ_ADDR_CTRL: begin
          regRdData <= {3'h0, ctrl_r};
        end
        `ADCSQ_ADDR_STAT: begin
          regRdData <= {10'h000, convChan_r, seqAddr_r,
            powerDown_r, busy};
        end
        `ADCSQ_ADDR_DATA: begin
          regRdData <= {2'h0, resultChannel, resultCode};
        end
        default: begin
          regRdData <= {`ADCSQ_RDATA_W{1'b0}};
        end
      endcase
    end else begin
      regRdData <= {`ADCSQ_RDATA_W{1'b0}};
    end
  end

endmodule // adcsq_sequencer

// file: verification/adcsq_analog_model.sv
// Analog input model that answers the comparator
`timescale 1ns/1ps
`include "adcsq_defs.vh"
module adcsq_analog_model (
  // Mux and trial word
  input wire [1:0] posSelect,
  input wire [`ADCSQ_RES-1:0] dacCode,
  // Comparator
  output wire compAbove
);
  // Input sits exactly on its code; a trial that ties counts as above
  wire [11:0] level = {posSelect, 10'h1A5};
  assign compAbove = level >= dacCode;
endmodule // adcsq_analog_model

// file: verification/adcsq_props.sv
// Timing and mux checks for the channel sequencer
`timescale 1ns/1ps
`include "adcsq_defs.vh"
module adcsq_props (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Register port
  input wire [1:0] regAddr,
  input wire [`ADCSQ_CTRL_W-1:0] regWrData,
  input wire regWrite,
  // Conversion and mux
  input wire convert_start_n,
  input wire busy,
  input wire dataValid,
  input wire [1:0] posSelect,
  input wire [1:0] negSelect,
  input wire negToGround,
  input wire sampleConnect,
  input wire [`ADCSQ_RES-1:0] dacCode
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  reg [`ADCSQ_CTRL_W-1:0] ctrl_r;
  // Shadow of the control word
  always @(posedge clock) begin
    if (reset)
      ctrl_r <= 13'h0000;
    else if (regWrite && regAddr == 2'h0)
      ctrl_r <= regWrData;
  end
  sequence startEv;
    $fell(convert_start_n) && !busy;
  endsequence
  sequence convOpen;
    busy && !sampleConnect && dacCode == 12'h800;
  endsequence
  sequence run12;
    busy[*8] ##1 busy[*5] ##1 (dataValid && !busy);
  endsequence
  sequence run10;
    busy[*8] ##1 busy[*3] ##1 (dataValid && !busy);
  endsequence
  start_opens_a: assert property (startEv |=> convOpen)
    else $error("inputs not opened at start");
  late_full_a: assert property (startEv ##0 !ctrl_r[12] |=> run12)
    else $error("12-bit timing off");
  late_ten_a: assert property (startEv ##0 ctrl_r[12] |=> run10)
    else $error("10-bit timing off");
  manual_chan_a: assert property (busy && ctrl_r[2:1] == 2'h0 |->
    posSelect == ctrl_r[6:5]) else $error("manual channel wrong");
  single_ground_a: assert property (busy |->
    negToGround == (ctrl_r[3] == ctrl_r[4])) else $error("ground tie wrong");
  pair_neg_a: assert property (busy && !negToGround |->
    negSelect == {posSelect[1], ~posSelect[0]}) else $error("pair wrong");
  no_swap_a: assert property (busy && ctrl_r[2:1] == 2'h3 &&
    !negToGround |-> !posSelect[0]) else $error("swapped pair converted");
  valid_pulse_a: assert property (dataValid |=> !dataValid)
    else $error("result strobe too long");
endmodule // adcsq_props

// file: verification/adcsq_sequencer_tb_top.sv
// Self-checking bench for the channel sequencer
`timescale 1ns/1ps
`include "adcsq_defs.vh"
module adcsq_sequencer_tb_top;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg [1:0] regAddr = 2'h0;
  reg [12:0] regWrData = 13'h0000;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg convert_start_n = 1'b1;
  wire [15:0] regRdData;
  wire [11:0] resultCode, dacCode;
  wire [1:0] resultChannel, posSelect, negSelect;
  wire busy, dataValid, negToGround, sampleConnect, rangeDouble;
  wire refInternal, compAbove, corePowered, refPowered, refBufPowered;
  wire [2:0] pwrEn = {corePowered, refPowered, refBufPowered};
  int error_cnt = 0;
  int n_checks = 0;
  logic [15:0] rdv;
  adcsq_sequencer u_dut (
    .clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .convert_start_n(convert_start_n),
    .busy(busy), .dataValid(dataValid), .resultCode(resultCode),
    .resultChannel(resultChannel), .posSelect(posSelect),
    .negSelect(negSelect), .negToGround(negToGround),
    .sampleConnect(sampleConnect), .rangeDouble(rangeDouble),
    .refInternal(refInternal), .compAbove(compAbove),
    .dacCode(dacCode), .corePowered(corePowered),
    .refPowered(refPowered), .refBufPowered(refBufPowered)
  );
  adcsq_analog_model u_analog (
    .posSelect(posSelect), .dacCode(dacCode), .compAbove(compAbove)
  );
  // 8 ns clock
  initial forever #4 clock = ~clock;
  function automatic [12:0] cw(input [1:0] s, m, a);
    cw = {6'h00, a, m, s, 1'b0};
  endfunction
  function automatic [11:0] lv(input [1:0] c);
    lv = {c, 10'h1A5};
  endfunction
  task chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [12:0] d);
    @(posedge clock);
    regAddr <= 2'h0;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [1:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    rdv = regRdData;
  endtask
  // One start pulse, then wait for the result strobe
  task conv(input logic [1:0] ch, input logic [11:0] code);
    int n;
    @(posedge clock);
    convert_start_n <= 1'b0;
    @(posedge clock);
    convert_start_n <= 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (dataValid !== 1'b1 && n < 40);
    chk({15'h0000, dataValid}, 16'h0001);
    chk({14'h0000, resultChannel}, {14'h0000, ch});
    chk({4'h0, resultCode}, {4'h0, code});
  endtask
  task t_manual;
    for (int c = 0; c < 4; c++) begin
      wr(cw(2'h0, 2'h0, c[1:0]));
      conv(c[1:0], lv(c[1:0]));
    end
    $display("manual test done");
  endtask
  // No writes inside a run, so the sequence is never restarted
  task t_seq;
    wr(cw(2'h3, 2'h0, 2'h2));
    for (int c = 0; c < 5; c++)
      conv(2'(c % 3), lv(2'(c % 3)));
    rd(2'h1);
    chk(rdv, 16'h001A);
    $display("sequence test done");
  endtask
  task t_pair;
    wr(cw(2'h3, 2'h2, 2'h3));
    for (int c = 0; c < 3; c++)
      conv(2'((c % 2) * 2), lv(2'((c % 2) * 2)));
    wr(cw(2'h3, 2'h1, 2'h1));
    conv(2'h0, lv(2'h0));
    conv(2'h0, lv(2'h0));
    $display("pair test done");
  endtask
  task t_code;
    wr(cw(2'h0, 2'h0, 2'h1) | 13'h0200);
    conv(2'h1, lv(2'h1) ^ 12'h800);
    wr(cw(2'h0, 2'h0, 2'h1) | 13'h1101);
    conv(2'h1, lv(2'h1) & 12'hFFC);
    chk({14'h0000, rangeDouble, refInternal}, 16'h0003);
    rd(2'h0);
    chk(rdv, 16'h1121);
    rd(2'h2);
    chk(rdv, {4'h1, lv(2'h1) & 12'hFFC});
    rd(2'h3);
    chk(rdv, 16'h0000);
    $display("coding test done");
  endtask
  task t_power;
    wr(cw(2'h0, 2'h0, 2'h0) | 13'h0800);
    conv(2'h0, lv(2'h0));
    @(negedge clock);
    chk({13'h0000, pwrEn}, 16'h0002);
    wr(13'h0400);
    conv(2'h0, lv(2'h0));
    @(negedge clock);
    chk({13'h0000, pwrEn}, 16'h0000);
    wr(13'h0C00);
    repeat (2) @(negedge clock);
    chk({13'h0000, pwrEn}, 16'h0000);
    wr(13'h0000);
    repeat (2) @(negedge clock);
    chk({13'h0000, pwrEn}, 16'h0007);
    $display("power test done");
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_manual;
    t_seq;
    t_pair;
    t_code;
    t_power;
    wrap_up;
  end
  // Watchdog: the run needs fewer than 400 cycles
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
endmodule // adcsq_sequencer_tb_top
bind adcsq_sequencer adcsq_props u_props (
  .clock(clock), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite),
  .convert_start_n(convert_start_n), .busy(busy),
  .dataValid(dataValid), .posSelect(posSelect),
  .negSelect(negSelect), .negToGround(negToGround),
  .sampleConnect(sampleConnect), .dacCode(dacCode)
);
